//--- hdl/irqtb_params.svh
// Offsets, field positions, reset values and counts of the interrupt and time base block.
`ifndef IRQTB_PARAMS_SVH
`define IRQTB_PARAMS_SVH
`define IRQTB_OFS_CTRL 8'h00
`define IRQTB_OFS_EN 8'h04
`define IRQTB_OFS_FLAG 8'h08
`define IRQTB_OFS_SRCF 8'h0C
`define IRQTB_OFS_SRCE 8'h10
`define IRQTB_OFS_PRESCALER_SOURCE_SELECT 8'h14
`define IRQTB_OFS_TBC 8'h18
`define IRQTB_OFS_VEC 8'h1C
`define IRQTB_NREQ 9
`define IRQTB_NSRC 16
`define IRQTB_POS_GIE 0
`define IRQTB_POS_TIME_BASE_ON 7
`define IRQTB_RST_PSC 2'h0
`define IRQTB_RST_TBR 3'h0
`define IRQTB_TB_BASE 8
`define IRQTB_RESP_OKAY 2'h0
`define IRQTB_RESP_SLVERR 2'h2
`endif

//--- hdl/irqtb_pkg.sv
// Types shared by the interrupt and time base block.
package irqtb_pkg;
  // Request sources in fixed priority order, first is highest.
  typedef enum logic [3:0] {
    SRC_LV, SRC_PROT, SRC_UART, SRC_EE, SRC_TB, SRC_MF0, SRC_MF1, SRC_MF2, SRC_MF3
  } irqtb_src_type;
  // One vectoring event towards the core.
  typedef struct packed {
    logic valid;
    irqtb_src_type id;
  } irqtb_vec_type;
endpackage : irqtb_pkg

//--- hdl/irqtb_top.sv
// Interrupt request, enable and vectoring logic with the time base and its prescaler.
//
// How it works
// - Low-voltage report sets low-voltage request flag.
// - Low-voltage vectors with global, own enable, stack free.
// - Taking low-voltage clears its flag and global enable.
// - Protection event sets protection request flag.
// - Protection vectors with global, own enable, stack free.
// - Taking protection clears its flag and global enable.
// - Any of six serial conditions raises serial interrupt.
// - Serial condition gives an active-low pulse.
// - Serial vectors with global, own enable, stack free.
// - Taking serial clears its flag and global enable.
// - Servicing leaves serial status flags untouched.
// - EEPROM erase or write end sets its flag.
// - EEPROM vectors with global, own enable, stack free.
// - Taking EEPROM clears its flag and global enable.
// - Divider overflow sets time-base flag; enables gate vector.
// - Taking time base clears its flag and global enable.
// - Source field picks system, system/4 or sub clock.
// - Time-base on bit enables divider, resets off.
// - Ratio field picks divider length, hence period.
// - Any grouped source event sets its group flag.
// - Group vectors need global, group, source enables.
// - Group service clears group flag, keeps source flags.
`timescale 1ns/1ps
`default_nettype none
`include "irqtb_params.svh"
module irqtb_top (
  input wire logic aclk, // System clock, 200 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic low_voltage, // Detector pin, high while supply is low.
  input wire logic motor_protection_event, // One-cycle protection event.
  input wire logic [5:0] uart_cond, // Serial conditions, level, high when present.
  input wire logic eeprom_cycle_done, // One-cycle end of erase or write.
  input wire logic [15:0] group_src_event, // One-cycle source events, four per group.
  input wire logic sub_clk, // Sub clock pin.
  input wire logic stack_full, // Core call stack is full.
  output irqtb_pkg::irqtb_vec_type vec, // Vector taken, one-cycle valid.
  output logic serial_irq_n // Active-low serial interrupt pulse.
);
  import irqtb_pkg::*;

  // Picks the lowest set bit, which is the highest priority.
  function automatic logic [8:0] prio_pick(input logic [8:0] r);
    logic [8:0] p;
    p = r & (~r + 9'h001);
    return p;
  endfunction : prio_pick

  // Turns a one-hot pick into its source index.
  function automatic logic [3:0] oh_index(input logic [8:0] oh);
    logic [3:0] i;
    i = 4'h0;
    for (int k = 0; k < `IRQTB_NREQ; k++)
      if (oh[k]) i = 4'(k);
    return i;
  endfunction : oh_index

  // True for every address that holds a register.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a <= `IRQTB_OFS_VEC) && (a[1:0] == 2'h0);
  endfunction : is_mapped

  // Mask of the low counter bits that must all be ones at overflow.
  function automatic logic [15:0] tb_mask(input logic [2:0] r);
    return 16'((17'h00001 << (`IRQTB_TB_BASE + r)) - 17'h00001);
  endfunction : tb_mask

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // Bus handshake state.
  logic [1:0] bresp_q, rresp_q; // Bus responses.
  logic [31:0] rdata_q, wdata_q; // Read data and held write data.
  logic [7:0] awaddr_q; // Held write address.
  logic [3:0] wstrb_q; // Held write strobes.
  logic global_irq_enable_q; // Global enable.
  logic [8:0] en_q; // Per request enables in source order.
  logic [8:0] flag_q; // Per request flags in source order.
  logic [15:0] srcf_q, srce_q; // Grouped source flags and enables.
  logic [1:0] prescaler_source_sel_q; // Prescaler clock source.
  logic time_base_on_q; // Time base running.
  logic [2:0] time_base_ratio_sel_q; // Divider length.
  logic [1:0] div4_q; // System clock divide by four counter.
  logic [15:0] tb_cnt_q; // Time base divider.
  logic lv_s1_q, lv_s2_q, lv_s3_q; // Low-voltage synchroniser and edge stage.
  logic sub_s1_q, sub_s2_q, sub_s3_q; // Sub clock synchroniser and edge stage.
  logic uart_any_q; // Serial conditions seen last cycle.
  logic serial_irq_n_q; // Serial pulse register.
  irqtb_vec_type vec_q; // Vector register.
  irqtb_src_type last_q; // Last vector taken, for software.

  // Write decode, fired once both address and data are held.
  wire wr_fire = !awready_q && !wready_q && !bvalid_q;
  wire wr_ok = wr_fire && is_mapped(awaddr_q);
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wd = wdata_q[15:0] & wmask;
  wire wr_ctrl = wr_ok && awaddr_q == `IRQTB_OFS_CTRL && wstrb_q[0];
  wire wr_en = wr_ok && awaddr_q == `IRQTB_OFS_EN;
  wire wr_flag = wr_ok && awaddr_q == `IRQTB_OFS_FLAG;
  wire wr_srcf = wr_ok && awaddr_q == `IRQTB_OFS_SRCF;
  wire wr_srce = wr_ok && awaddr_q == `IRQTB_OFS_SRCE;
  wire wr_prescaler_source_select = wr_ok && awaddr_q == `IRQTB_OFS_PRESCALER_SOURCE_SELECT && wstrb_q[0];
  wire wr_tbc = wr_ok && awaddr_q == `IRQTB_OFS_TBC && wstrb_q[0];

  // Prescaler tick: every cycle, every fourth cycle, or each sub clock rise.
  wire sub_rise = sub_s2_q && !sub_s3_q;
  wire psc_tick = prescaler_source_sel_q[1] ? sub_rise :
                  prescaler_source_sel_q[0] ? (div4_q == 2'h3) : 1'b1;
  wire tb_ovf = time_base_on_q && psc_tick &&
                ((tb_cnt_q & tb_mask(time_base_ratio_sel_q)) ==
                 tb_mask(time_base_ratio_sel_q));

  // Event sources that set request flags.
  wire lv_rise = lv_s2_q && !lv_s3_q;
  wire uart_any = |uart_cond;
  wire uart_pulse = uart_any && !uart_any_q;
  wire [3:0] grp_set;
  wire [3:0] grp_ok;
  for (genvar g = 0; g < 4; g++)
  begin : g_grp
    assign grp_set[g] = |group_src_event[g*4 +: 4];
    assign grp_ok[g] = |(srcf_q[g*4 +: 4] & srce_q[g*4 +: 4]);
  end
  wire [8:0] set_v = {grp_set, tb_ovf, eeprom_cycle_done, uart_pulse,
                      motor_protection_event, lv_rise};

  // A request is eligible when flagged, enabled and, for groups, backed by a source.
  wire [8:0] req_ok = flag_q & en_q & {grp_ok, 5'h1F};
  wire [8:0] pick = prio_pick(req_ok);
  wire take = global_irq_enable_q && !stack_full && (req_ok != 9'h000);
  wire [8:0] take_oh = take ? pick : 9'h000;
  wire [8:0] flag_clr = (wr_flag ? wd[8:0] : 9'h000) | take_oh;
  // A new event in the clearing cycle survives, the set wins.
  wire [8:0] flag_d = (flag_q & ~flag_clr) | set_v;
  // Source flags clear only by software; servicing never touches them.
  wire [15:0] srcf_d = (srcf_q & ~(wr_srcf ? wd : 16'h0000)) | group_src_event;
  // Servicing clears the global enable, and wins over a software write that cycle.
  wire gie_d = take ? 1'b0 : wr_ctrl ? wdata_q[`IRQTB_POS_GIE] : global_irq_enable_q;

  // Read multiplexer; unmapped addresses read zero with an error.
  wire [7:0] ra = araddr;
  wire [31:0] rd_mux =
    (ra == `IRQTB_OFS_CTRL) ? {31'h0, global_irq_enable_q} :
    (ra == `IRQTB_OFS_EN) ? {23'h0, en_q} :
    (ra == `IRQTB_OFS_FLAG) ? {23'h0, flag_q} :
    (ra == `IRQTB_OFS_SRCF) ? {16'h0, srcf_q} :
    (ra == `IRQTB_OFS_SRCE) ? {16'h0, srce_q} :
    (ra == `IRQTB_OFS_PRESCALER_SOURCE_SELECT) ? {30'h0, prescaler_source_sel_q} :
    (ra == `IRQTB_OFS_TBC) ? {24'h0, time_base_on_q, 4'h0, time_base_ratio_sel_q} :
    (ra == `IRQTB_OFS_VEC) ? {28'h0, last_q} : 32'h0000_0000;

  // Write channel: address and data are taken in either order, then answered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `IRQTB_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? `IRQTB_RESP_OKAY : `IRQTB_RESP_SLVERR;
      end
      // Readies return only after the answer, so one write is in flight.
      if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel: data is captured at the address handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `IRQTB_RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= is_mapped(araddr) ? `IRQTB_RESP_OKAY : `IRQTB_RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {lv_s1_q, lv_s2_q, lv_s3_q, sub_s1_q, sub_s2_q, sub_s3_q} <= 6'h00;
    else
      {lv_s1_q, lv_s2_q, lv_s3_q, sub_s1_q, sub_s2_q, sub_s3_q} <=
        {low_voltage, lv_s1_q, lv_s2_q, sub_clk, sub_s1_q, sub_s2_q};
  end

  // Control registers written by software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q <= 9'h000;
      srce_q <= 16'h0000;
      prescaler_source_sel_q <= `IRQTB_RST_PSC;
      time_base_on_q <= 1'b0;
      time_base_ratio_sel_q <= `IRQTB_RST_TBR;
    end
    else
    begin
      if (wr_en) en_q <= (en_q & ~wmask[8:0]) | wd[8:0];
      if (wr_srce) srce_q <= (srce_q & ~wmask) | wd;
      if (wr_prescaler_source_select) prescaler_source_sel_q <= wdata_q[1:0];
      if (wr_tbc)
      begin
        time_base_on_q <= wdata_q[`IRQTB_POS_TIME_BASE_ON];
        time_base_ratio_sel_q <= wdata_q[2:0];
      end
    end
  end

  // Prescaler and time base divider; the divider holds while switched off.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div4_q <= 2'h0;
      tb_cnt_q <= 16'h0000;
    end
    else
    begin
      div4_q <= div4_q + 2'h1;
      if (time_base_on_q && psc_tick) tb_cnt_q <= tb_cnt_q + 16'h0001;
    end
  end

  // Flags, global enable, vector and serial pulse.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= 9'h000;
      srcf_q <= 16'h0000;
      global_irq_enable_q <= 1'b0;
      vec_q <= '{valid: 1'b0, id: SRC_LV};
      last_q <= SRC_LV;
      uart_any_q <= 1'b0;
      serial_irq_n_q <= 1'b1;
    end
    else
    begin
      flag_q <= flag_d;
      srcf_q <= srcf_d;
      global_irq_enable_q <= gie_d;
      vec_q <= '{valid: take, id: irqtb_src_type'(oh_index(pick))};
      if (take) last_q <= irqtb_src_type'(oh_index(pick));
      uart_any_q <= uart_any;
      // Serial status levels are only observed here, never cleared.
      serial_irq_n_q <= !uart_pulse;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign vec = vec_q;
  assign serial_irq_n = serial_irq_n_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A taken vector names the first pending request of the previous cycle.
  sequence s_taken;
    vec_q.valid;
  endsequence
  sequence s_div4_run;
    (prescaler_source_sel_q == 2'h1)[*4];
  endsequence

  a_lv_flag_set: assert property (lv_rise |=> flag_q[SRC_LV])
    else $error("low-voltage flag not set");
  // The id register moves every cycle, so past words are indexed with the id shown now.
  a_take_gated: assert property (s_taken |-> $past(global_irq_enable_q) &&
    !$past(stack_full) && ((($past(req_ok) >> vec_q.id) & 9'h001) == 9'h001))
    else $error("vector without enables");
  a_take_clears: assert property (s_taken ##0
    ((($past(set_v) >> vec_q.id) & 9'h001) == 9'h000) |->
    !global_irq_enable_q && !flag_q[vec_q.id]) else $error("service did not clear");
  a_prot_set: assert property (motor_protection_event |=> flag_q[SRC_PROT])
    else $error("protection flag not set");
  a_uart_pulse: assert property (uart_pulse |=> !serial_irq_n_q ##1 serial_irq_n_q)
    else $error("serial pulse wrong");
  a_ee_set: assert property (eeprom_cycle_done |=> flag_q[SRC_EE])
    else $error("eeprom flag not set");
  a_tb_off_hold: assert property (!time_base_on_q |=> $stable(tb_cnt_q))
    else $error("time base ran while off");
  a_tb_flag_set: assert property (tb_ovf |=> flag_q[SRC_TB])
    else $error("time base flag not set");
  a_psc_div4: assert property (prescaler_source_sel_q == 2'h1 && psc_tick ##1
    s_div4_run |-> psc_tick && !$past(psc_tick, 1) && !$past(psc_tick, 2) &&
    !$past(psc_tick, 3)) else $error("divide by four tick wrong");
  a_grp_set: assert property (group_src_event[4] |=> flag_q[SRC_MF1] && srcf_q[4])
    else $error("group flag not set");
  a_grp_keep: assert property (take && pick[8:5] != 4'h0 && !wr_srcf |=>
    (srcf_q & $past(srcf_q)) == $past(srcf_q)) else $error("source flag lost");
  a_prio_first: assert property (s_taken |->
    ($past(req_ok) & ((9'h001 << vec_q.id) - 9'h001)) == 9'h000)
    else $error("lower priority taken first");
endmodule : irqtb_top
`default_nettype wire

//--- verif/irqtb_core_model.sv
// Core-side model that takes vectors and reports a full call stack.
`timescale 1ns/1ps
`default_nettype none
module irqtb_core_model (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire irqtb_pkg::irqtb_vec_type vec, // Vector offered by the block.
  input wire logic full_req, // Bench asks for a full stack.
  output logic stack_full, // Stack full towards the block.
  output logic [7:0] taken, // Vectors taken so far.
  output irqtb_pkg::irqtb_src_type last_id // Source of the last vector.
);
  import irqtb_pkg::*;
  // The stack level moves only after an edge, so a full request lands one cycle late.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_full <= 1'b0;
      taken <= 8'h00;
      last_id <= SRC_LV;
    end
    else
    begin
      stack_full <= full_req;
      // Every one-cycle valid is one subroutine call.
      if (vec.valid)
      begin
        taken <= taken + 8'h01;
        last_id <= vec.id;
      end
    end
  end
endmodule : irqtb_core_model
`default_nettype wire

//--- verif/irq_sources_and_time_base_bench.sv
// Self-checking bench for the interrupt and time base block.
`timescale 1ns/1ps
`default_nettype none
`include "irqtb_params.svh"
module irq_sources_and_time_base_bench;
  import irqtb_pkg::*;
  localparam logic [1:0] OK = `IRQTB_RESP_OKAY;
  localparam logic [1:0] SE = `IRQTB_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, stack_full, serial_irq_n;
  logic [1:0] bresp, rresp;
  logic low_voltage = 1'b0, prot_ev = 1'b0, ee_done = 1'b0, full_req = 1'b0;
  logic [5:0] uart_cond = 6'h00;
  logic [15:0] grp_ev = 16'h0000;
  irqtb_vec_type vec;
  irqtb_src_type last_id;
  logic [7:0] taken, n0;
  int errors = 0;
  int n_tests = 0;
  int lows = 0;
  // Sub clock at one eighth of the system clock, moved on the rising edge like other inputs.
  logic [2:0] sub_div = 3'h0;
  irqtb_top dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .low_voltage, .motor_protection_event(prot_ev), .uart_cond,
    .eeprom_cycle_done(ee_done), .group_src_event(grp_ev), .sub_clk(sub_div[2]), .stack_full,
    .vec, .serial_irq_n
  );
  irqtb_core_model core_u (.aclk, .aresetn, .vec, .full_req, .stack_full, .taken, .last_id);
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
    sub_div <= sub_div + 3'h1;
  // Cycles spent low on the serial line; a level instead of a pulse shows up here.
  always @(posedge aclk)
  begin
    if (serial_irq_n !== 1'b1)
      lows <= lows + 1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Address and data go out together; each is dropped at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1'b1)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        check("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1'b1)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        check("rdata", rdata, e);
        check("rresp", 32'(rresp), 32'(er));
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  // Waits, bounded, for exactly one more vector from the given source.
  task automatic expect_vec(input irqtb_src_type id, input int lim);
    repeat (lim)
    begin
      @(posedge aclk);
      if (taken != n0)
        break;
    end
    check("vec_count", 32'(taken), 32'(n0 + 8'h01));
    check("vec_id", 32'(last_id), 32'(id));
    n0 = taken;
  endtask : expect_vec
  task automatic expect_none(input int cyc);
    repeat (cyc) @(posedge aclk);
    check("no_vec", 32'(taken), 32'(n0));
  endtask : expect_none
  task automatic t_regs();
    repeat (300) @(posedge aclk);
    rd(`IRQTB_OFS_CTRL, 32'h0, OK);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    rd(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'h0, OK);
    rd(`IRQTB_OFS_TBC, 32'h0, OK);
    wr(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'hFF, OK);
    rd(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'h3, OK);
    wr(`IRQTB_OFS_TBC, 32'h7F, OK);
    rd(`IRQTB_OFS_TBC, 32'h7, OK);
    wr(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'h0, OK);
    wr(`IRQTB_OFS_TBC, 32'h0, OK);
    wr(8'h40, 32'h1, SE);
    rd(8'h40, 32'h0, SE);
    wr(`IRQTB_OFS_EN, 32'h1FF, OK);
    n0 = taken;
  endtask : t_regs
  // Two requests wait with the global enable off; the stack then holds the second.
  task automatic t_prio();
    low_voltage <= 1'b1;
    ee_done <= 1'b1;
    @(posedge aclk);
    ee_done <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(`IRQTB_OFS_FLAG, 32'h9, OK);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_vec(SRC_LV, 20);
    rd(`IRQTB_OFS_FLAG, 32'h8, OK);
    rd(`IRQTB_OFS_CTRL, 32'h0, OK);
    full_req <= 1'b1;
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_none(10);
    full_req <= 1'b0;
    expect_vec(SRC_EE, 20);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    low_voltage <= 1'b0;
  endtask : t_prio
  task automatic t_prot();
    prot_ev <= 1'b1;
    @(posedge aclk);
    prot_ev <= 1'b0;
    expect_none(5);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_vec(SRC_PROT, 20);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    rd(`IRQTB_OFS_CTRL, 32'h0, OK);
  endtask : t_prot
  // Each of the six serial conditions rises alone and is held for three cycles.
  task automatic t_uart();
    int l0;
    l0 = lows;
    for (int k = 0; k < 6; k++)
    begin
      uart_cond <= 6'h01 << k;
      repeat (3) @(posedge aclk);
      uart_cond <= 6'h00;
      repeat (3) @(posedge aclk);
    end
    check("low_pulses", 32'(lows - l0), 32'h6);
    rd(`IRQTB_OFS_FLAG, 32'h4, OK);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_vec(SRC_UART, 20);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    rd(`IRQTB_OFS_CTRL, 32'h0, OK);
  endtask : t_uart
  task automatic t_group();
    grp_ev <= 16'h0010;
    @(posedge aclk);
    grp_ev <= 16'h0000;
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_none(6);
    rd(`IRQTB_OFS_FLAG, 32'h40, OK);
    wr(`IRQTB_OFS_SRCE, 32'h10, OK);
    expect_vec(SRC_MF1, 20);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    rd(`IRQTB_OFS_SRCF, 32'h10, OK);
    wr(`IRQTB_OFS_SRCF, 32'h10, OK);
    rd(`IRQTB_OFS_SRCF, 32'h0, OK);
  endtask : t_group
  // Ratio 0 on the system clock overflows every 256 cycles.
  task automatic t_tb();
    wr(`IRQTB_OFS_TBC, 32'h80, OK);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_vec(SRC_TB, 300);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_none(200);
    expect_vec(SRC_TB, 100);
    rd(`IRQTB_OFS_FLAG, 32'h0, OK);
    wr(`IRQTB_OFS_TBC, 32'h0, OK);
  endtask : t_tb
  // Ratio 0 takes 256 prescaler ticks, so the slower sources stretch the period in cycles.
  // The first wait starts from wherever the held divider stopped, hence the wide limit.
  task automatic t_rate(input logic [1:0] sel, input int period);
    wr(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'(sel), OK);
    rd(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'(sel), OK);
    wr(`IRQTB_OFS_TBC, 32'h80, OK);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_vec(SRC_TB, period + 100);
    wr(`IRQTB_OFS_CTRL, 32'h1, OK);
    expect_none(period - 100);
    expect_vec(SRC_TB, 200);
    wr(`IRQTB_OFS_TBC, 32'h0, OK);
    wr(`IRQTB_OFS_PRESCALER_SOURCE_SELECT, 32'h0, OK);
  endtask : t_rate
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prio();
    t_prot();
    t_uart();
    t_group();
    t_tb();
    t_rate(2'h1, 1024);
    t_rate(2'h2, 2048);
    tally_and_finish();
  end
  // The whole run needs about 8000 cycles, so this only fires on a hang.
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end
endmodule : irq_sources_and_time_base_bench
`default_nettype wire
